// ===== design/bscan_bsr.sv
`timescale 1ns/1ps
`include "bscan_params.svh"
module bscan_bsr #(
	parameter int PINS = `BSCAN_BSR_LEN / `BSCAN_CELLS_PER_PIN
) (
	input wire logic tck,
	input wire logic rst_n,
	bscan_scan_if.chain scan,
	input wire logic [PINS-1:0] pin_in,
	input wire logic [PINS-1:0] core_out,
	input wire logic [PINS-1:0] core_oe,
	output logic [PINS-1:0] upd_out,
	output logic [PINS-1:0] upd_oe
);
	localparam int LEN = PINS * `BSCAN_CELLS_PER_PIN;
	logic [LEN-1:0] cells;
	logic [LEN-1:0] next_cells;
	logic [PINS-1:0] next_upd_out;
	logic [PINS-1:0] next_upd_oe;

	// cell 3i = input pin, 3i+1 = output data, 3i+2 = output enable
	always_comb begin
		next_cells = cells;
		next_upd_out = upd_out;
		next_upd_oe = upd_oe;
		if (scan.en && scan.capture) begin
			for (int i = 0; i < PINS; i++) begin
				next_cells[3*i] = pin_in[i]; // [RULE_03] [RULE_04]
				next_cells[3*i+1] = core_out[i]; // [RULE_03]
				next_cells[3*i+2] = core_oe[i];
			end
		end else if (scan.en && scan.shift) begin
			next_cells = {scan.si, cells[LEN-1:1]};
		end else if (scan.en && scan.update) begin
			for (int i = 0; i < PINS; i++) begin
				next_upd_out[i] = cells[3*i+1]; // [RULE_03]
				next_upd_oe[i] = cells[3*i+2];
			end
		end
	end

	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			cells <= '0;
			upd_out <= '0;
			upd_oe <= '0;
		end else begin
			cells <= next_cells;
			upd_out <= next_upd_out;
			upd_oe <= next_upd_oe;
		end
	end

	assign scan.so = cells[0];
endmodule : bscan_bsr

// ===== design/bscan_params.svh
`ifndef BSCAN_PARAMS_SVH
`define BSCAN_PARAMS_SVH

// instruction register
`define BSCAN_IR_LEN 10
`define BSCAN_IR_CAPTURE 10'h001

// opcodes; any other code selects the bypass bit
`define BSCAN_OP_EXTEST 10'h000
`define BSCAN_OP_SAMPLE 10'h005
`define BSCAN_OP_IDENTIFICATION_REGISTER 10'h006
`define BSCAN_OP_USER_CODE_REGISTER 10'h007
`define BSCAN_OP_CONFIG 10'h002
`define BSCAN_OP_ANALYZE 10'h00E
`define BSCAN_OP_CLAMP 10'h00A
`define BSCAN_OP_HIGHZ 10'h00B
`define BSCAN_OP_BYPASS 10'h3FF

// identification word fields, msb first; values arbitrary except the fixed lsb of one
`define BSCAN_ID_LEN 32
`define BSCAN_ID_VERSION 4'h1
`define BSCAN_ID_PART 16'h5A3C
`define BSCAN_ID_MAKER 11'h2A5
`define BSCAN_ID_FIXED 1'b1

// data register sizes
`define BSCAN_USR_LEN 32
`define BSCAN_USER_CODE 32'h0000_0000
`define BSCAN_BSR_LEN 1524
`define BSCAN_CELLS_PER_PIN 3
`define BSCAN_CFG_W 8
`define BSCAN_ANA_W 16

`endif

// ===== design/bscan_pkg.sv
package bscan_pkg;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
		TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
		TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
	} bscan_tap_t;

	typedef enum logic [2:0] {
		PATH_BYP, PATH_BSR, PATH_ID, PATH_USR, PATH_CFG, PATH_ANA
	} bscan_path_t;
endpackage : bscan_pkg

// ===== design/bscan_scan_if.sv
`timescale 1ns/1ps
interface bscan_scan_if;
	logic en;
	logic capture;
	logic shift;
	logic update;
	logic si;
	logic so;
	modport ctrl (output en, output capture, output shift, output update,
		output si, input so);
	modport chain (input en, input capture, input shift, input update,
		input si, output so);
endinterface : bscan_scan_if

// ===== design/bscan_sync.sv
`timescale 1ns/1ps
module bscan_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// meta feeds q only
	always_comb begin
		next_meta = d;
		next_q = meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end
endmodule : bscan_sync

// ===== design/bscan_tap_top.sv
// Contract
// RULE_01: no boundary tests during configuration
// RULE_02: instruction register is ten bits long
// RULE_03: sample captures pins, preload stages pattern
// RULE_04: extest drives pattern, captures input pins
// RULE_05: bypass puts one bit between tdi/tdo
// RULE_06: highz selects bypass, floats all pins
// RULE_07: clamp selects bypass, holds scanned levels
// RULE_08: keepers override test high impedance
// RULE_09: user_code_register shifts 32-bit user code out
// RULE_10: identification_register shifts identification word out
// RULE_11: id fields version, part, maker, one
// RULE_12: scan chain length set by device size
// RULE_13: config instruction loads configuration data
// RULE_14: analyzer instruction monitors internal probes
// RULE_15: sixteen-state tap, sample rise, tdo falls
// RULE_16: opcodes parameters, unknown selects bypass
`timescale 1ns/1ps
`include "bscan_params.svh"
module bscan_tap_top #(
	parameter int BSR_LEN = `BSCAN_BSR_LEN,
	parameter logic [31:0] USER_CODE = `BSCAN_USER_CODE,
	parameter int CFG_W = `BSCAN_CFG_W,
	parameter int ANA_W = `BSCAN_ANA_W,
	parameter int PINS = BSR_LEN / `BSCAN_CELLS_PER_PIN
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic cfg_busy,
	input wire logic [PINS-1:0] pin_in,
	input wire logic [PINS-1:0] core_out,
	input wire logic [PINS-1:0] core_oe,
	input wire logic [PINS-1:0] keep_en,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	output logic [PINS-1:0] pin_keep,
	input wire logic [ANA_W-1:0] probe,
	output logic ana_snap,
	output logic [CFG_W-1:0] cfg_word,
	output logic cfg_strobe
);
	localparam logic [`BSCAN_ID_LEN-1:0] ID_VALUE = {`BSCAN_ID_VERSION,
		`BSCAN_ID_PART, `BSCAN_ID_MAKER, `BSCAN_ID_FIXED};

	bscan_pkg::bscan_tap_t state;
	bscan_pkg::bscan_tap_t next_state;
	bscan_pkg::bscan_path_t path;
	logic en_t;
	logic busy_t;
	logic [PINS-1:0] pin_s;
	logic [ANA_W-1:0] probe_s;
	logic [`BSCAN_IR_LEN-1:0] ir_shift;
	logic [`BSCAN_IR_LEN-1:0] next_ir_shift;
	logic [`BSCAN_IR_LEN-1:0] test_instruction_register;
	logic [`BSCAN_IR_LEN-1:0] next_test_instruction_register;
	logic byp;
	logic next_byp;
	logic [`BSCAN_ID_LEN-1:0] identification_register;
	logic [`BSCAN_ID_LEN-1:0] next_identification_register;
	logic [`BSCAN_USR_LEN-1:0] user_code_register;
	logic [`BSCAN_USR_LEN-1:0] next_user_code_register;
	logic [CFG_W-1:0] cfg_sr;
	logic [CFG_W-1:0] next_cfg_sr;
	logic [CFG_W-1:0] cfg_hold;
	logic [CFG_W-1:0] next_cfg_hold;
	logic cfg_tog;
	logic next_cfg_tog;
	logic [ANA_W-1:0] ana_sr;
	logic [ANA_W-1:0] next_ana_sr;
	logic next_ana_snap;
	logic bsr_act;
	logic drv;
	logic hiz;
	logic tdo_mux;
	logic next_tdo;
	logic next_tdo_oe;
	logic tog_s;
	logic tog_d;
	logic next_tog_d;
	logic next_cfg_strobe;
	logic [CFG_W-1:0] next_cfg_word;
	logic [PINS-1:0] upd_out;
	logic [PINS-1:0] upd_oe;
	logic [PINS-1:0] cout_s;
	logic [PINS-1:0] coe_s;

	bscan_scan_if scan ();

	// link-side copies of core levels; multi-bit probe and pin words are
	// not coherent across bits, a known limit of a plain two-flop crossing
	bscan_sync #(.W(2)) u_sync_ctl (
		.clk(tck), .rst_n(rst_n), .d({clk_en, cfg_busy}), .q({en_t, busy_t})
	);
	bscan_sync #(.W(PINS)) u_sync_pin (
		.clk(tck), .rst_n(rst_n), .d(pin_in), .q(pin_s)
	);
	bscan_sync #(.W(ANA_W)) u_sync_probe (
		.clk(tck), .rst_n(rst_n), .d(probe), .q(probe_s)
	);
	// core drive levels are core-clock state; cross before capture
	bscan_sync #(.W(2*PINS)) u_sync_core (
		.clk(tck), .rst_n(rst_n), .d({core_out, core_oe}),
		.q({cout_s, coe_s})
	);
	bscan_sync #(.W(1)) u_sync_cfg (
		.clk(ref_clk), .rst_n(rst_n), .d(cfg_tog), .q(tog_s)
	);

	// tap controller
	always_comb begin
		next_state = state;
		if (en_t) begin
			case (state) // [RULE_15]
			bscan_pkg::TAP_RESET: next_state = tms ? bscan_pkg::TAP_RESET :
				bscan_pkg::TAP_IDLE;
			bscan_pkg::TAP_IDLE: next_state = tms ? bscan_pkg::TAP_SEL_DR :
				bscan_pkg::TAP_IDLE;
			bscan_pkg::TAP_SEL_DR: next_state = tms ? bscan_pkg::TAP_SEL_IR :
				bscan_pkg::TAP_CAP_DR;
			bscan_pkg::TAP_CAP_DR: next_state = tms ? bscan_pkg::TAP_EX1_DR :
				bscan_pkg::TAP_SH_DR;
			bscan_pkg::TAP_SH_DR: next_state = tms ? bscan_pkg::TAP_EX1_DR :
				bscan_pkg::TAP_SH_DR;
			bscan_pkg::TAP_EX1_DR: next_state = tms ? bscan_pkg::TAP_UPD_DR :
				bscan_pkg::TAP_PA_DR;
			bscan_pkg::TAP_PA_DR: next_state = tms ? bscan_pkg::TAP_EX2_DR :
				bscan_pkg::TAP_PA_DR;
			bscan_pkg::TAP_EX2_DR: next_state = tms ? bscan_pkg::TAP_UPD_DR :
				bscan_pkg::TAP_SH_DR;
			bscan_pkg::TAP_UPD_DR: next_state = tms ? bscan_pkg::TAP_SEL_DR :
				bscan_pkg::TAP_IDLE;
			bscan_pkg::TAP_SEL_IR: next_state = tms ? bscan_pkg::TAP_RESET :
				bscan_pkg::TAP_CAP_IR;
			bscan_pkg::TAP_CAP_IR: next_state = tms ? bscan_pkg::TAP_EX1_IR :
				bscan_pkg::TAP_SH_IR;
			bscan_pkg::TAP_SH_IR: next_state = tms ? bscan_pkg::TAP_EX1_IR :
				bscan_pkg::TAP_SH_IR;
			bscan_pkg::TAP_EX1_IR: next_state = tms ? bscan_pkg::TAP_UPD_IR :
				bscan_pkg::TAP_PA_IR;
			bscan_pkg::TAP_PA_IR: next_state = tms ? bscan_pkg::TAP_EX2_IR :
				bscan_pkg::TAP_PA_IR;
			bscan_pkg::TAP_EX2_IR: next_state = tms ? bscan_pkg::TAP_UPD_IR :
				bscan_pkg::TAP_SH_IR;
			bscan_pkg::TAP_UPD_IR: next_state = tms ? bscan_pkg::TAP_SEL_DR :
				bscan_pkg::TAP_IDLE;
			default: next_state = bscan_pkg::TAP_RESET;
			endcase
		end
	end

	// instruction decode
	always_comb begin
		path = bscan_pkg::PATH_BYP;
		bsr_act = 1'b0;
		drv = 1'b0;
		hiz = 1'b0;
		case (test_instruction_register)
		`BSCAN_OP_EXTEST: begin
			path = bscan_pkg::PATH_BSR;
			bsr_act = 1'b1;
			drv = 1'b1; // [RULE_04]
		end
		`BSCAN_OP_SAMPLE: begin
			path = bscan_pkg::PATH_BSR; // [RULE_03]
			bsr_act = 1'b1;
		end
		`BSCAN_OP_IDENTIFICATION_REGISTER: path = bscan_pkg::PATH_ID; // [RULE_10]
		`BSCAN_OP_USER_CODE_REGISTER: path = bscan_pkg::PATH_USR; // [RULE_09]
		`BSCAN_OP_CONFIG: path = bscan_pkg::PATH_CFG; // [RULE_13]
		`BSCAN_OP_ANALYZE: path = bscan_pkg::PATH_ANA; // [RULE_14]
		`BSCAN_OP_CLAMP: drv = 1'b1; // [RULE_07]
		`BSCAN_OP_HIGHZ: hiz = 1'b1; // [RULE_06]
		`BSCAN_OP_BYPASS: path = bscan_pkg::PATH_BYP; // [RULE_05]
		default: path = bscan_pkg::PATH_BYP; // [RULE_16]
		endcase
	end

	// instruction and data registers
	always_comb begin
		next_ir_shift = ir_shift;
		next_test_instruction_register = test_instruction_register;
		next_byp = byp;
		next_identification_register = identification_register;
		next_user_code_register = user_code_register;
		next_cfg_sr = cfg_sr;
		next_cfg_hold = cfg_hold;
		next_cfg_tog = cfg_tog;
		next_ana_sr = ana_sr;
		next_ana_snap = 1'b0;
		if (en_t) begin
			case (state)
			bscan_pkg::TAP_RESET: next_test_instruction_register =
				`BSCAN_OP_IDENTIFICATION_REGISTER;
			bscan_pkg::TAP_CAP_IR: next_ir_shift = `BSCAN_IR_CAPTURE;
			bscan_pkg::TAP_SH_IR: next_ir_shift =
				{tdi, ir_shift[`BSCAN_IR_LEN-1:1]}; // [RULE_02]
			bscan_pkg::TAP_UPD_IR: next_test_instruction_register = ir_shift;
			bscan_pkg::TAP_CAP_DR: begin
				next_byp = 1'b0;
				next_identification_register = ID_VALUE; // [RULE_11]
				next_user_code_register = USER_CODE; // [RULE_09]
				next_ana_sr = probe_s; // [RULE_14]
				// a sample snapshot also arms the analyzer
				next_ana_snap = test_instruction_register ==
					`BSCAN_OP_SAMPLE; // [RULE_14]
			end
			bscan_pkg::TAP_SH_DR: begin
				case (path)
				bscan_pkg::PATH_BYP: next_byp = tdi; // [RULE_05]
				bscan_pkg::PATH_ID: next_identification_register =
					{tdi, identification_register[`BSCAN_ID_LEN-1:1]};
				bscan_pkg::PATH_USR: next_user_code_register =
					{tdi, user_code_register[`BSCAN_USR_LEN-1:1]};
				bscan_pkg::PATH_CFG: next_cfg_sr = {tdi, cfg_sr[CFG_W-1:1]};
				bscan_pkg::PATH_ANA: next_ana_sr = {tdi, ana_sr[ANA_W-1:1]};
				default: next_byp = byp;
				endcase
			end
			bscan_pkg::TAP_UPD_DR: begin
				if (path == bscan_pkg::PATH_CFG) begin
					next_cfg_hold = cfg_sr; // [RULE_13]
					next_cfg_tog = ~cfg_tog;
				end
			end
			default: next_byp = byp;
			endcase
		end
	end

	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			state <= bscan_pkg::TAP_RESET;
			ir_shift <= '0;
			test_instruction_register <= `BSCAN_OP_IDENTIFICATION_REGISTER;
			byp <= 1'b0;
			identification_register <= '0;
			user_code_register <= '0;
			cfg_sr <= '0;
			cfg_hold <= '0;
			cfg_tog <= 1'b0;
			ana_sr <= '0;
			ana_snap <= 1'b0;
		end else begin
			state <= next_state;
			ir_shift <= next_ir_shift;
			test_instruction_register <= next_test_instruction_register;
			byp <= next_byp;
			identification_register <= next_identification_register;
			user_code_register <= next_user_code_register;
			cfg_sr <= next_cfg_sr;
			cfg_hold <= next_cfg_hold;
			cfg_tog <= next_cfg_tog;
			ana_sr <= next_ana_sr;
			ana_snap <= next_ana_snap;
		end
	end

	// boundary chain; frozen while configuring so a test cannot corrupt it
	assign scan.en = en_t & bsr_act & ~busy_t; // [RULE_01]
	assign scan.capture = state == bscan_pkg::TAP_CAP_DR;
	assign scan.shift = state == bscan_pkg::TAP_SH_DR;
	assign scan.update = state == bscan_pkg::TAP_UPD_DR;
	assign scan.si = tdi;

	bscan_bsr #(.PINS(PINS)) u_bsr ( // [RULE_12]
		.tck(tck),
		.rst_n(rst_n),
		.scan(scan),
		.pin_in(pin_s),
		.core_out(cout_s),
		.core_oe(coe_s),
		.upd_out(upd_out),
		.upd_oe(upd_oe)
	);

	// pad control; test modes released while configuring
	always_comb begin
		pin_out = core_out;
		pin_oe = core_oe;
		if (hiz && !busy_t) begin
			pin_oe = '0; // [RULE_06]
		end else if (drv && !busy_t) begin
			pin_out = upd_out; // [RULE_04] [RULE_07]
			pin_oe = upd_oe;
		end
		pin_keep = keep_en & ~pin_oe &
			{PINS{(hiz | drv) & ~busy_t}}; // [RULE_08]
	end

	// tdo changes on the falling edge
	always_comb begin
		tdo_mux = byp;
		if (state == bscan_pkg::TAP_SH_IR) begin
			tdo_mux = ir_shift[0];
		end else begin
			case (path)
			bscan_pkg::PATH_BSR: tdo_mux = scan.so;
			bscan_pkg::PATH_ID: tdo_mux = identification_register[0];
			bscan_pkg::PATH_USR: tdo_mux = user_code_register[0];
			bscan_pkg::PATH_CFG: tdo_mux = cfg_sr[0];
			bscan_pkg::PATH_ANA: tdo_mux = ana_sr[0];
			default: tdo_mux = byp;
			endcase
		end
		next_tdo = en_t ? tdo_mux : tdo;
		next_tdo_oe = en_t ? (state == bscan_pkg::TAP_SH_IR ||
			state == bscan_pkg::TAP_SH_DR) : tdo_oe;
	end

	always_ff @(negedge tck or negedge rst_n) begin
		if (!rst_n) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo <= next_tdo; // [RULE_15]
			tdo_oe <= next_tdo_oe;
		end
	end

	// core side: toggle crossing carries the configuration word
	always_comb begin
		next_tog_d = clk_en ? tog_s : tog_d;
		next_cfg_strobe = clk_en & (tog_s ^ tog_d); // [RULE_13]
		next_cfg_word = next_cfg_strobe ? cfg_hold : cfg_word;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tog_d <= 1'b0;
			cfg_strobe <= 1'b0;
			cfg_word <= '0;
		end else begin
			tog_d <= next_tog_d;
			cfg_strobe <= next_cfg_strobe;
			cfg_word <= next_cfg_word;
		end
	end

	sequence s_cap_dr;
		en_t && state == bscan_pkg::TAP_CAP_DR;
	endsequence

	sequence s_tms_high;
		en_t && tms;
	endsequence

	AST_TAP_RESET: assert property (@(posedge tck) disable iff (!rst_n) // [RULE_15]
		s_tms_high [*5] |=> state == bscan_pkg::TAP_RESET)
		else $error("tap not in reset after five tms highs");
	AST_IR_LOAD: assert property (@(posedge tck) disable iff (!rst_n) // [RULE_02]
		en_t && state == bscan_pkg::TAP_UPD_IR |=>
		test_instruction_register == $past(ir_shift))
		else $error("instruction not loaded from shift stage");
	AST_BYPASS: assert property (@(posedge tck) disable iff (!rst_n) // [RULE_05]
		en_t && state == bscan_pkg::TAP_SH_DR && path == bscan_pkg::PATH_BYP
		|=> byp == $past(tdi))
		else $error("bypass bit did not take tdi");
	AST_ID_WORD: assert property (@(posedge tck) disable iff (!rst_n) // [RULE_11]
		s_cap_dr |=> identification_register == ID_VALUE &&
		identification_register[0])
		else $error("identification word wrong after capture");
	AST_USER_CODE_REGISTER: assert property (@(posedge tck) disable iff (!rst_n) // [RULE_09]
		s_cap_dr ##1 (en_t && state == bscan_pkg::TAP_SH_DR &&
		path == bscan_pkg::PATH_USR) |-> ##1 user_code_register ==
		{$past(tdi), USER_CODE[31:1]})
		else $error("user code did not shift toward tdo");
	AST_HIGHZ: assert property (@(posedge tck) disable iff (!rst_n) // [RULE_06]
		hiz && !busy_t |-> pin_oe == '0)
		else $error("pins driven under high impedance test");
	AST_CLAMP: assert property (@(posedge tck) disable iff (!rst_n) // [RULE_07]
		drv && !hiz && !busy_t |-> pin_out == upd_out && pin_oe == upd_oe)
		else $error("pins not held at scanned levels");
	AST_KEEP: assert property (@(posedge tck) disable iff (!rst_n) // [RULE_08]
		(hiz && !busy_t) |-> pin_keep == keep_en)
		else $error("keeper not enabled over high impedance");
	AST_BUSY: assert property (@(posedge tck) disable iff (!rst_n) // [RULE_01]
		busy_t && en_t && state == bscan_pkg::TAP_UPD_DR |=>
		$stable(upd_out) && $stable(upd_oe))
		else $error("boundary chain active during configuration");
	AST_UNKNOWN_OP: assert property (@(posedge tck) disable iff (!rst_n) // [RULE_16]
		test_instruction_register == 10'h155 |-> path == bscan_pkg::PATH_BYP)
		else $error("unassigned opcode did not select bypass");
	AST_CFG_STROBE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_13]
		cfg_strobe |=> !cfg_strobe)
		else $error("configuration strobe longer than one cycle");
endmodule : bscan_tap_top

// ===== verification/bstp_jtag_host.sv
`timescale 1ns/1ps
module bstp_jtag_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	int oe_miss;
	logic oe_at;

	// tck stands low between frames, so the link clock only runs in frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		oe_miss = 0;
		oe_at = 1'b0;
	end

	// tms/tdi move just after the falling edge, tdo is read at the rise
	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#40;
		q = tdo;
		oe_at = tdo_oe;
		tck = 1'b1;
		#40;
		tck = 1'b0;
	endtask : tick

	// outside shift states tdi carries the inverse of its last value
	task automatic step(input logic m);
		logic q;
		tick(m, ~tdi, q);
	endtask : step

	// odd offset keeps tck edges away from the core clock edges
	task automatic reset_tap();
		#7;
		repeat (5) step(1'b1);
		step(1'b0);
	endtask : reset_tap

	task automatic idle(input int n);
		#7;
		repeat (n) step(1'b0);
	endtask : idle

	// one whole scan from idle back to idle, lsb first
	task automatic scan(input bit ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic q;
		dout = '0;
		#7;
		step(1'b1);
		if (ir) begin
			step(1'b1);
		end
		step(1'b0);
		step(1'b0);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
			if (oe_at !== 1'b1) begin
				oe_miss++;
			end
		end
		step(1'b1);
		step(1'b0);
	endtask : scan
endmodule : bstp_jtag_host

// ===== verification/tb_boundary_scan_test_port.sv
`timescale 1ns/1ps
`include "bscan_params.svh"
module tb_boundary_scan_test_port;
	localparam int BL = 12;
	localparam int PN = 4;
	localparam logic [31:0] UC = 32'h3C5A_96E1;

	logic ref_clk, rst_n, clk_en, cfg_busy;
	logic tck, tms, tdi, tdo, tdo_oe, ana_snap, cfg_strobe;
	logic [PN-1:0] pin_in, core_out, core_oe, keep_en;
	logic [PN-1:0] pin_out, pin_oe, pin_keep;
	logic [15:0] probe;
	logic [7:0] cfg_word, got_cfg;
	logic [63:0] d;
	int n_fail, compares, n_snap, n_cfg;

	bscan_tap_top #(.BSR_LEN(BL), .USER_CODE(UC)) u_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.cfg_busy(cfg_busy), .pin_in(pin_in), .core_out(core_out),
		.core_oe(core_oe), .keep_en(keep_en), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_keep(pin_keep), .probe(probe),
		.ana_snap(ana_snap), .cfg_word(cfg_word), .cfg_strobe(cfg_strobe)
	);

	bstp_jtag_host host (
		.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	always @(posedge tck) begin
		if (ana_snap === 1'b1) n_snap++;
	end

	always @(posedge ref_clk) begin
		if (cfg_strobe === 1'b1) begin
			got_cfg = cfg_word;
			n_cfg++;
		end
	end

	task automatic check(input string name, input logic [63:0] seen,
		input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d failures %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	// cell 3i pin level, 3i+1 output data, 3i+2 output enable
	function automatic logic [63:0] chain(input logic [PN-1:0] p,
		input logic [PN-1:0] o, input logic [PN-1:0] e);
		logic [63:0] v;
		v = '0;
		for (int i = 0; i < PN; i++) begin
			v[3*i] = p[i];
			v[3*i+1] = o[i];
			v[3*i+2] = e[i];
		end
		return v;
	endfunction : chain

	// 20 bits through the ir: the capture word, then our own filler
	task automatic load_ir(input logic [9:0] op);
		host.scan(1'b1, 20, {44'h0, op, 10'h2AA}, d);
		check("ir_out", d, {44'h0, 10'h2AA, `BSCAN_IR_CAPTURE});
	endtask : load_ir

	task automatic by_check();
		host.scan(1'b0, 8, 64'hB5, d);
		check("bypass", d, 64'h6A);
	endtask : by_check

	task automatic t_ident();
		host.scan(1'b0, 32, 64'h0, d);
		check("identification_register", d, {32'h0, `BSCAN_ID_VERSION, `BSCAN_ID_PART,
			`BSCAN_ID_MAKER, `BSCAN_ID_FIXED});
		load_ir(`BSCAN_OP_USER_CODE_REGISTER);
		host.scan(1'b0, 32, 64'h0, d);
		check("user_code_register", d, {32'h0, UC});
	endtask : t_ident

	task automatic t_sample();
		int s0;
		s0 = n_snap;
		load_ir(`BSCAN_OP_SAMPLE);
		host.scan(1'b0, BL, chain(4'h0, 4'h9, 4'h3), d);
		check("sample_cap", d, chain(pin_in, core_out, core_oe));
		check("sample_out", 64'(pin_out), 64'(core_out));
		check("sample_oe", 64'(pin_oe), 64'(core_oe));
		check("snap_count", 64'(n_snap - s0), 64'd1);
	endtask : t_sample

	// preloaded pattern is data 9, enable 3
	task automatic t_modes();
		load_ir(`BSCAN_OP_CLAMP);
		check("clamp_out", 64'(pin_out), 64'h9);
		check("clamp_oe", 64'(pin_oe), 64'h3);
		check("clamp_keep", 64'(pin_keep), 64'h4);
		by_check();
		load_ir(`BSCAN_OP_HIGHZ);
		check("highz_oe", 64'(pin_oe), 64'h0);
		check("highz_keep", 64'(pin_keep), 64'(keep_en));
		by_check();
		load_ir(`BSCAN_OP_BYPASS);
		by_check();
		// tap frozen while clk_en is low: the reset walk must not land
		@(posedge ref_clk);
		clk_en <= 1'b0;
		host.idle(3);
		host.reset_tap();
		@(posedge ref_clk);
		clk_en <= 1'b1;
		host.idle(3);
		by_check();
		load_ir(10'h155);
		by_check();
	endtask : t_modes

	task automatic t_extest();
		@(posedge ref_clk);
		pin_in <= 4'h3;
		host.idle(3);
		load_ir(`BSCAN_OP_EXTEST);
		check("ext_pre_out", 64'(pin_out), 64'h9);
		host.scan(1'b0, BL, chain(4'h0, 4'h5, 4'hF), d);
		check("ext_cap", d, chain(4'h3, core_out, core_oe));
		check("ext_out", 64'(pin_out), 64'h5);
		check("ext_oe", 64'(pin_oe), 64'hF);
		@(posedge ref_clk);
		cfg_busy <= 1'b1;
		host.idle(4);
		check("busy_out", 64'(pin_out), 64'(core_out));
		check("busy_oe", 64'(pin_oe), 64'(core_oe));
		host.scan(1'b0, BL, chain(4'h0, 4'hA, 4'h0), d);
		check("busy_scan", d, 64'h0);
		check("busy_hold", 64'(pin_out), 64'(core_out));
		@(posedge ref_clk);
		cfg_busy <= 1'b0;
		host.idle(4);
		check("free_out", 64'(pin_out), 64'h5);
		check("free_oe", 64'(pin_oe), 64'hF);
	endtask : t_extest

	task automatic t_analyze();
		load_ir(`BSCAN_OP_ANALYZE);
		host.scan(1'b0, 16, 64'h0, d);
		check("probe", d, 64'(probe));
		check("tdo_oe", 64'(host.oe_miss), 64'd0);
	endtask : t_analyze

	// updates here sit far more than four core cycles apart
	task automatic t_config();
		logic [7:0] w [2];
		int c0;
		w = '{8'hC3, 8'h3C};
		load_ir(`BSCAN_OP_CONFIG);
		foreach (w[k]) begin
			c0 = n_cfg;
			host.scan(1'b0, 8, 64'(w[k]), d);
			repeat (8) @(posedge ref_clk);
			check("cfg_count", 64'(n_cfg - c0), 64'd1);
			check("cfg_word", 64'(got_cfg), 64'(w[k]));
		end
	endtask : t_config

	initial begin
		#1000000;
		n_fail++;
		close_out();
	end

	initial begin
		n_fail = 0;
		compares = 0;
		n_snap = 0;
		n_cfg = 0;
		got_cfg = 8'h00;
		rst_n = 1'b0;
		clk_en = 1'b1;
		cfg_busy = 1'b0;
		pin_in = 4'hA;
		core_out = 4'h6;
		core_oe = 4'hC;
		keep_en = 4'h5;
		probe = 16'hB3D1;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		host.reset_tap();
		t_ident();
		t_sample();
		t_modes();
		t_extest();
		t_analyze();
		t_config();
		close_out();
	end
endmodule : tb_boundary_scan_test_port
